// ---- hdl/hpa_consts.svh ----
// Constants for the headphone amplifier serial control port.
// Assumes inclusion by bare name from both ends, the link checks and the bench.
`ifndef HPA_CONSTS_SVH
`define HPA_CONSTS_SVH
`define HPA_DEV_ADDR 7'h60
`define HPA_REG_CFG 1'h0
`define HPA_REG_GAIN 1'h1
`define HPA_SEL_BIT 7
`define HPA_CFG_LEFT_OFF 6
`define HPA_CFG_BIAS_OFF 5
`define HPA_CFG_PUMP_ONLY 4
`define HPA_CFG_LEFT_MUTE 2
`define HPA_CFG_RIGHT_OFF 1
`define HPA_CFG_RIGHT_MUTE 0
`define HPA_GAIN_POWER_DOWN 6
`define HPA_CFG_RESET 8'h00
`define HPA_GAIN_RESET 8'h40
`define HPA_CLK_PERIOD_NS 10
`define HPA_SCL_MIN_PERIOD_NS 2500
`define HPA_SCL_HALF_CYC ((`HPA_SCL_MIN_PERIOD_NS + 2 * `HPA_CLK_PERIOD_NS - 1) / (2 * `HPA_CLK_PERIOD_NS))
`endif

// ---- hdl/hpa_pkg.sv ----
// Types shared by both ends of the headphone amplifier control link.
// Assumes hpa_consts.svh holds the numeric constants.
package hpa_pkg;
    typedef logic [7:0] hpa_byte_t;
    typedef logic [5:0] hpa_gain_t;
endpackage

// ---- hdl/hpa_link_if.sv ----
// Two-wire link between the control master and the amplifier slave.
// The interface resolves the open-drain data wire from the two enables.
`timescale 1ns/1ps
interface hpa_link_if;
    logic scl;
    logic sda_m_oe;
    logic sda_s_oe;
    logic sda;
    assign sda = ~(sda_m_oe | sda_s_oe);
    modport master (output scl, output sda_m_oe, input sda);
    modport slave (input scl, output sda_s_oe, input sda);
endinterface

// ---- hdl/hpa_slave.sv ----
// Amplifier end: write-only two-wire slave with two control registers.
// Assumes scl and sda come from outside ref_clk and are synchronised here.
`timescale 1ns/1ps
module hpa_slave (
    input wire logic ref_clk,
    input wire logic resetn,
    hpa_link_if.slave link,
    output logic left_channel_off_ff,
    output logic right_channel_off_ff,
    output logic bias_off_ff,
    output logic pump_only_mode_ff,
    output logic left_mute_ff,
    output logic right_mute_ff,
    output logic right_to_left_ff,
    output logic global_power_down_ff,
    output hpa_pkg::hpa_gain_t gain_code_ff
);
    import hpa_pkg::*;
    `include "hpa_consts.svh"

    // A mismatched or read address parks the machine in the wait state until
    // the next start or stop; it never touches the data wire there.
    typedef enum logic [2:0] {
        HPA_IDLE = 3'b000,
        HPA_ADDR = 3'b001,
        HPA_AACK = 3'b010,
        HPA_DATA = 3'b011,
        HPA_DACK = 3'b100,
        HPA_WAIT = 3'b101
    } hpa_state_e;

    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic scl_d_ff;
    logic sda_d_ff;
    hpa_state_e state_ff;
    hpa_byte_t shift_ff;
    logic [3:0] bit_cnt_ff;
    logic ack_oe_ff;
    hpa_byte_t cfg_ff;
    hpa_byte_t gain_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    hpa_byte_t nxt_shift;
    logic addr_match;
    logic commit_byte;

    // Three flops per pin; the second flop and its delayed copy feed the edge logic.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], link.scl};
            sda_sync_ff <= {sda_sync_ff[0], link.sda};
            scl_d_ff <= scl_sync_ff[1];
            sda_d_ff <= sda_sync_ff[1];
        end
    end

    // The delayed copies start high, matching the idle bus, so no false edge follows reset.
    assign scl_rise = scl_sync_ff[1] & ~scl_d_ff;
    assign scl_fall = ~scl_sync_ff[1] & scl_d_ff;
    // Data moving while the clock is high marks framing, not data.
    assign start_seen = scl_sync_ff[1] & scl_d_ff & sda_d_ff & ~sda_sync_ff[1];
    assign stop_seen = scl_sync_ff[1] & scl_d_ff & ~sda_d_ff & sda_sync_ff[1];
    assign nxt_shift = {shift_ff[6:0], sda_sync_ff[1]};

    // The direction bit is part of the compare, so a read request never matches.
    assign addr_match = (shift_ff == {`HPA_DEV_ADDR, 1'b0});

    // Framing wins over data, so a byte cut by start or stop is dropped.
    assign commit_byte = (state_ff == HPA_DATA) && scl_fall && (bit_cnt_ff == 4'h8)
                         && !start_seen && !stop_seen;

    // Start and stop are checked before the bit logic so that a new start
    // always restarts the address phase, even in the middle of a byte.
    // The acknowledge is raised on a falling clock edge and dropped on the next
    // one, so it is stable for the whole high phase of the acknowledge clock.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_ff <= HPA_IDLE;
            shift_ff <= 8'h00;
            bit_cnt_ff <= 4'h0;
            ack_oe_ff <= 1'b0;
        end else if (start_seen) begin
            state_ff <= HPA_ADDR;
            bit_cnt_ff <= 4'h0;
            ack_oe_ff <= 1'b0;
        end else if (stop_seen) begin
            state_ff <= HPA_IDLE;
            ack_oe_ff <= 1'b0;
        end else begin
            case (state_ff)
                HPA_ADDR, HPA_DATA: begin
                    if (scl_rise) begin
                        shift_ff <= nxt_shift;
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    if (scl_fall && bit_cnt_ff == 4'h8) begin
                        bit_cnt_ff <= 4'h0;
                        if (state_ff == HPA_DATA) begin
                            state_ff <= HPA_DACK;
                            ack_oe_ff <= 1'b1;
                        end else if (addr_match) begin
                            state_ff <= HPA_AACK;
                            ack_oe_ff <= 1'b1;
                        end else begin
                            state_ff <= HPA_WAIT;
                        end
                    end
                end
                HPA_AACK, HPA_DACK: begin
                    // Release only on the falling edge so data holds while clock is high.
                    if (scl_fall) begin
                        ack_oe_ff <= 1'b0;
                        state_ff <= (state_ff == HPA_AACK) ? HPA_DATA : HPA_WAIT;
                    end
                end
                HPA_IDLE, HPA_WAIT: begin
                    ack_oe_ff <= 1'b0;
                end
                default: begin
                    state_ff <= HPA_IDLE;
                    ack_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // Commit when the eighth bit falls, so a cut transfer changes nothing.
    // With no documented power-on value, the gain register comes up with the
    // global power-down bit set so the amplifier stays quiet until written.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cfg_ff <= `HPA_CFG_RESET;
            gain_ff <= `HPA_GAIN_RESET;
        end else if (commit_byte) begin
            if (shift_ff[`HPA_SEL_BIT] == `HPA_REG_CFG) begin
                cfg_ff <= shift_ff;
            end else begin
                gain_ff <= shift_ff;
            end
        end
    end

    // Outputs are re-registered so every pin comes straight from a flop.
    // Pump-only mode overrides both channel enables and the bias, whatever the
    // individual shutdown bits hold; the raw bit is still reported for status.
    // Right-channel shutdown routes the right inputs to the left output, but
    // not in pump-only mode, where both amplifiers are off anyway.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            left_channel_off_ff <= 1'b0;
            right_channel_off_ff <= 1'b0;
            bias_off_ff <= 1'b0;
            pump_only_mode_ff <= 1'b0;
            left_mute_ff <= 1'b0;
            right_mute_ff <= 1'b0;
            right_to_left_ff <= 1'b0;
            global_power_down_ff <= 1'b1;
            gain_code_ff <= 6'h00;
        end else begin
            left_channel_off_ff <= cfg_ff[`HPA_CFG_LEFT_OFF] | cfg_ff[`HPA_CFG_PUMP_ONLY];
            right_channel_off_ff <= cfg_ff[`HPA_CFG_RIGHT_OFF] | cfg_ff[`HPA_CFG_PUMP_ONLY];
            bias_off_ff <= cfg_ff[`HPA_CFG_BIAS_OFF] | cfg_ff[`HPA_CFG_PUMP_ONLY];
            pump_only_mode_ff <= cfg_ff[`HPA_CFG_PUMP_ONLY];
            left_mute_ff <= cfg_ff[`HPA_CFG_LEFT_MUTE];
            right_mute_ff <= cfg_ff[`HPA_CFG_RIGHT_MUTE];
            right_to_left_ff <= cfg_ff[`HPA_CFG_RIGHT_OFF] & ~cfg_ff[`HPA_CFG_PUMP_ONLY];
            global_power_down_ff <= gain_ff[`HPA_GAIN_POWER_DOWN];
            gain_code_ff <= gain_ff[5:0];
        end
    end

    assign link.sda_s_oe = ack_oe_ff;
endmodule

// ---- hdl/hpa_master.sv ----
// Control end: two-wire master that writes one register byte per order.
// Assumes the slave answers with open-drain acknowledge on the data wire.
`timescale 1ns/1ps
`include "hpa_consts.svh"
module hpa_master #(
    parameter int HALF_CYC = `HPA_SCL_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    hpa_link_if.master link,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data_ff
);
    import hpa_pkg::*;

    typedef enum logic [2:0] {
        HPM_IDLE = 3'b000,
        HPM_START = 3'b001,
        HPM_BITS = 3'b010,
        HPM_STOP = 3'b011,
        HPM_END = 3'b100
    } hpm_state_e;

    hpm_state_e state_ff;
    logic [15:0] tick_ff;
    logic [1:0] phase_ff;
    logic [4:0] bit_ff;
    logic [17:0] frame_ff;
    logic busy_ff;
    logic nack_ff;
    logic scl_ff;
    logic sda_oe_ff;
    logic [1:0] sda_sync_ff;
    logic tick;

    assign tick = (tick_ff == 16'(HALF_CYC - 1));

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sda_sync_ff <= 2'h3;
        end else begin
            sda_sync_ff <= {sda_sync_ff[0], link.sda};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn || state_ff == HPM_IDLE || tick) begin
            tick_ff <= 16'h0000;
        end else begin
            tick_ff <= tick_ff + 16'h0001;
        end
    end

    // Each bit takes three half periods: two with clock low, then one with clock high.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_ff <= HPM_IDLE;
            scl_ff <= 1'b1;
            sda_oe_ff <= 1'b0;
            bit_ff <= 5'h00;
            phase_ff <= 2'h0;
            frame_ff <= 18'h00000;
            busy_ff <= 1'b0;
            nack_ff <= 1'b0;
        end else begin
            case (state_ff)
                HPM_IDLE: begin
                    if (wr_en && wr_addr == 8'h00 && !busy_ff) begin
                        frame_ff <= {`HPA_DEV_ADDR, 1'b0, 1'b1, wr_data, 1'b1};
                        busy_ff <= 1'b1;
                        nack_ff <= 1'b0;
                        state_ff <= HPM_START;
                    end
                end
                HPM_START: begin
                    if (tick) begin
                        sda_oe_ff <= 1'b1;
                        state_ff <= HPM_BITS;
                        bit_ff <= 5'h00;
                        phase_ff <= 2'h0;
                    end
                end
                HPM_BITS: begin
                    if (tick) begin
                        if (phase_ff == 2'h0) begin
                            scl_ff <= 1'b0;
                            phase_ff <= 2'h1;
                        end else if (phase_ff == 2'h1) begin
                            sda_oe_ff <= ~frame_ff[17];
                            phase_ff <= 2'h2;
                        end else begin
                            scl_ff <= ~scl_ff;
                            if (scl_ff) begin
                                if ((bit_ff == 5'd8 || bit_ff == 5'd17) && sda_sync_ff[1]) begin
                                    nack_ff <= 1'b1;
                                end
                                frame_ff <= {frame_ff[16:0], 1'b0};
                                bit_ff <= bit_ff + 5'h01;
                                phase_ff <= (bit_ff == 5'd17) ? 2'h3 : 2'h1;
                                if (bit_ff == 5'd17 || (bit_ff == 5'd8 && sda_sync_ff[1])) begin
                                    state_ff <= HPM_STOP;
                                end
                            end
                        end
                    end
                end
                HPM_STOP: begin
                    if (tick) begin
                        if (scl_ff) begin
                            scl_ff <= 1'b0;
                        end else if (!sda_oe_ff) begin
                            sda_oe_ff <= 1'b1;
                        end else begin
                            scl_ff <= 1'b1;
                            state_ff <= HPM_END;
                        end
                    end
                end
                HPM_END: begin
                    if (tick) begin
                        sda_oe_ff <= 1'b0;
                        busy_ff <= 1'b0;
                        state_ff <= HPM_IDLE;
                    end
                end
                default: state_ff <= HPM_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rd_data_ff <= 8'h00;
        end else if (rd_en) begin
            rd_data_ff <= {6'h00, nack_ff, busy_ff};
        end else begin
            rd_data_ff <= 8'h00;
        end
    end

    assign link.scl = scl_ff;
    assign link.sda_m_oe = sda_oe_ff;
endmodule

// ---- test/hpa_link_asserts.sv ----
// Checks on the link that joins the control master and the amplifier slave.
// Assumes both ends run on ref_clk and the bench wires the link in by name.
`timescale 1ns/1ps
`include "hpa_consts.svh"
module hpa_link_asserts #(
    parameter int HALF_CYC = 4
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe,
    input wire logic sda
);
    logic scl_ff;
    logic sda_ff;
    logic frame_ff;
    logic [4:0] cnt_ff;
    logic [7:0] addr_ff;
    logic [9:0] gap_ff;
    wire rise = scl && !scl_ff;
    wire start = scl && scl_ff && sda_ff && !sda;
    wire stop = scl && scl_ff && !sda_ff && sda;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // The first byte is complete in addr_ff by the ninth rise; later bits are not kept.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            frame_ff <= 1'b0;
            cnt_ff <= 5'h00;
            gap_ff <= 10'h000;
        end else begin
            scl_ff <= scl;
            sda_ff <= sda;
            if (start || stop) frame_ff <= start;
            if (start || stop) cnt_ff <= 5'h00;
            else if (rise) cnt_ff <= cnt_ff + 5'h01;
            if (rise && cnt_ff < 5'h08) addr_ff <= {addr_ff[6:0], sda};
            gap_ff <= rise ? 10'h000 : gap_ff + {9'h000, gap_ff != 10'h3FF};
        end
    end
    slave_change_low_a: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("slave data moved in clock high");
    ack_hold_a: assert property ($rose(sda_s_oe) |-> ##[1:40] (scl && sda_s_oe))
        else $error("ack not held into clock high");
    ack_slot_a: assert property (rise && sda_s_oe |-> cnt_ff == 5'h08 || cnt_ff == 5'h11)
        else $error("ack outside its slot");
    ack_match_a: assert property (rise && cnt_ff == 5'h08 |->
        sda_s_oe == (addr_ff == {`HPA_DEV_ADDR, 1'b0})) else $error("address ack wrong");
    ack_release_a: assert property (rise && (cnt_ff == 5'h08 || cnt_ff == 5'h11)
        |-> !sda_m_oe) else $error("master drove ack slot");
    frame_len_a: assert property (rise |-> cnt_ff < 5'h13)
        else $error("too many clocks in frame");
    scl_framed_a: assert property ($fell(scl) |-> frame_ff)
        else $error("clock outside frame");
    scl_rate_a: assert property (rise && cnt_ff != 5'h00 |-> gap_ff >= 2 * HALF_CYC - 1)
        else $error("clock period too short");
    cover property (start);
    cover property (stop);
    cover property (rise && cnt_ff == 5'h11 && sda_s_oe);
endmodule

// ---- test/headphone_amp_i2c_control_tb.sv ----
// Bench: master and slave on one link, a second slave bit-banged on another.
// Assumes the constants header and package are compiled first.
`timescale 1ns/1ps
`include "hpa_consts.svh"
module headphone_amp_i2c_control_tb;
    import hpa_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    hpa_byte_t wr_addr = 8'h00;
    hpa_byte_t wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    wire [7:0] rd_data;
    wire [13:0] o1;
    wire [13:0] o2;
    hpa_byte_t cfg = `HPA_CFG_RESET;
    hpa_byte_t gn = `HPA_GAIN_RESET;
    hpa_byte_t vals [6] = '{8'h65, 8'h12, 8'h02, 8'hBF, 8'h81, 8'h00};
    hpa_byte_t fa [4] = '{8'hC2, 8'hC1, 8'hC0, 8'hC0};
    int fn [4] = '{8, 8, 4, 8};
    logic [1:0] fx [4] = '{2'h0, 2'h0, 2'h2, 2'h3};
    int err_total = 0;
    int tests_run = 0;
    hpa_link_if lk();
    hpa_link_if lk2();
    hpa_master #(.HALF_CYC(4)) hpa_master_i (.ref_clk(ref_clk), .resetn(resetn), .link(lk),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_ff(rd_data));
    hpa_slave hpa_slave_i (.ref_clk(ref_clk), .resetn(resetn), .link(lk),
        .left_channel_off_ff(o1[13]), .right_channel_off_ff(o1[12]), .bias_off_ff(o1[11]),
        .pump_only_mode_ff(o1[10]), .left_mute_ff(o1[9]), .right_mute_ff(o1[8]),
        .right_to_left_ff(o1[7]), .global_power_down_ff(o1[6]), .gain_code_ff(o1[5:0]));
    hpa_slave hpa_slave_x_i (.ref_clk(ref_clk), .resetn(resetn), .link(lk2),
        .left_channel_off_ff(o2[13]), .right_channel_off_ff(o2[12]), .bias_off_ff(o2[11]),
        .pump_only_mode_ff(o2[10]), .left_mute_ff(o2[9]), .right_mute_ff(o2[8]),
        .right_to_left_ff(o2[7]), .global_power_down_ff(o2[6]), .gain_code_ff(o2[5:0]));
    hpa_link_asserts #(.HALF_CYC(4)) hpa_link_asserts_i (.ref_clk(ref_clk), .resetn(resetn),
        .scl(lk.scl), .sda_m_oe(lk.sda_m_oe), .sda_s_oe(lk.sda_s_oe), .sda(lk.sda));
    // Pump-only overrides every channel and the bias, so it is folded in here.
    function automatic logic [13:0] model(hpa_byte_t c, hpa_byte_t g);
        return {c[6] | c[4], c[1] | c[4], c[5] | c[4], c[4], c[2], c[0],
            c[1] & ~c[4], g[6], g[5:0]};
    endfunction
    task automatic chk(string n, logic [13:0] e, logic [13:0] s);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(hpa_byte_t a, hpa_byte_t d);
        wr_addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(output hpa_byte_t d);
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
        @(posedge ref_clk);
    endtask
    task automatic send(hpa_byte_t d);
        hpa_byte_t s;
        wr(8'h00, d);
        rd(s);
        for (int i = 0; i < 400 && s[0] !== 1'b0; i++) rd(s);
        chk("link status", 14'h0, {12'h0, s[1:0]});
        if (d[7]) gn = d;
        else cfg = d;
        repeat (8) @(posedge ref_clk);
        #1 chk("amp controls", model(cfg, gn), o1);
        @(posedge ref_clk);
    endtask
    // Sets data mid-low, samples mid-high; s tells whether the wire was pulled low.
    task automatic bb(logic b, output logic s);
        #31 lk2.sda_m_oe = ~b;
        #31 lk2.scl = 1'b1;
        #31 s = (lk2.sda === 1'b0);
        #32 lk2.scl = 1'b0;
    endtask
    task automatic frame(hpa_byte_t a, int n, output logic [1:0] ack);
        logic s;
        ack = 2'h0;
        #60 lk2.sda_m_oe = 1'b1;
        #60 lk2.scl = 1'b0;
        for (int i = 0; i < 8; i++) bb(a[7 - i], s);
        bb(1'b1, ack[1]);
        for (int i = 0; i < n; i++) bb(8'h96 >> (7 - i), s);
        if (n == 8) bb(1'b1, ack[0]);
        #31 lk2.sda_m_oe = 1'b1;
        #31 lk2.scl = 1'b1;
        #31 lk2.sda_m_oe = 1'b0;
    endtask
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #300000;
        err_total++;
        $display("Error watchdog expected done seen hang");
        results();
    end
    initial begin
        hpa_byte_t s;
        logic [1:0] ack;
        lk2.scl = 1'b1;
        lk2.sda_m_oe = 1'b0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        wr(8'h05, 8'h81);
        rd(s);
        chk("unmapped busy", 14'h0, {13'h0, s[0]});
        #1 chk("reset controls", model(cfg, gn), o1);
        @(posedge ref_clk);
        for (int i = 0; i < 6; i++) send(vals[i]);
        for (int i = 0; i < 4; i++) begin
            frame(fa[i], fn[i], ack);
            chk("acks", {12'h0, fx[i]}, {12'h0, ack});
            chk("far controls", model(`HPA_CFG_RESET, i == 3 ? 8'h96 : `HPA_GAIN_RESET), o2);
        end
        results();
    end
endmodule
